/* File: hdl/udfp_pkg.sv */
// Shared constants, types and helpers of the DMA FIFO port control block
package udfp_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_SELECT      = 8'h30;   // dma_port_pipe_select_control
   localparam logic [7:0]  ADDR_STATUS      = 8'h34;   // dma_port_buffer_status
   localparam logic [7:0]  ADDR_TXN         = 8'h36;   // transaction counter / limit

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int          SEL_READ_COUNT_MODE_BIT     = 15;
   localparam int          SEL_REW_BIT      = 14;
   localparam int          SEL_AUTO_CLEAR_MODE_BIT     = 13;
   localparam int          SEL_MBW_BIT      = 10;
   localparam int          SEL_TXEN_BIT     = 9;
   localparam int          SEL_TXCLR_BIT    = 8;
   localparam int          SEL_PIPE_LSB     = 0;
   localparam int          PIPE_W           = 3;
   localparam int          ST_BUFFER_VALID_BIT      = 15;
   localparam int          ST_FLUSH_BIT     = 14;
   localparam int          ST_RDY_BIT       = 13;
   localparam int          LEN_W            = 10;
   localparam int          TXN_W            = 16;
   localparam logic [15:0] REG_RESET        = 16'h0000;
   localparam logic [2:0]  PIPE_NONE        = 3'h0;
   localparam logic [2:0]  PIPE_INVALID     = 3'h7;
   localparam logic [9:0]  LEN_ZERO         = 10'h000;
   localparam logic [9:0]  STEP_BYTE        = 10'h001;
   localparam logic [9:0]  STEP_HALF        = 10'h002;

   // Buffer state of the selected pipe, Gray along idle-valid-held
   typedef enum logic [1:0] {
      UDFP_BUF_IDLE  = 2'b00,
      UDFP_BUF_VALID = 2'b01,
      UDFP_BUF_HELD  = 2'b11
   } udfp_buf_e;

   // Bytes moved by one data register access at the chosen width
   function automatic logic [9:0] udfp_step(input logic half_wide);
      udfp_step = half_wide ? STEP_HALF : STEP_BYTE;
   endfunction : udfp_step

   // Carry-keeping sum of two lengths
   function automatic logic [10:0] udfp_add(input logic [9:0] a, input logic [9:0] b);
      udfp_add = {1'b0, a} + {1'b0, b};
   endfunction : udfp_add

endpackage : udfp_pkg

/* File: hdl/udfp_units.sv */
// Receive length tracker and transaction counter of the DMA FIFO port
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Receive byte count
// ----------------------------------------------------------------
module udfp_len_tracker import udfp_pkg::*; (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             clear_in,
   input  wire logic             load_in,
   input  wire logic [LEN_W-1:0] load_val_in,
   input  wire logic             dec_in,
   input  wire logic [LEN_W-1:0] step_in,
   output logic      [LEN_W-1:0] len_out
);
   // Clear beats load beats decrement; saturates so an odd tail cannot wrap
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         len_out <= LEN_ZERO;
      end else if (clear_in) begin
         len_out <= LEN_ZERO;
      end else if (load_in) begin
         len_out <= load_val_in;
      end else if (dec_in) begin
         len_out <= (len_out > step_in) ? len_out - step_in : LEN_ZERO;
      end
   end
endmodule : udfp_len_tracker

// ----------------------------------------------------------------
// Transaction counter
// ----------------------------------------------------------------
module udfp_txn_counter import udfp_pkg::*; (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             limit_wr_in,
   input  wire logic [TXN_W-1:0] limit_in,
   input  wire logic             enable_in,
   input  wire logic             clear_in,
   input  wire logic             packet_in,
   input  wire logic             short_in,
   output logic      [TXN_W-1:0] count_out,
   output logic                  reached_out
);
   logic [TXN_W-1:0] limit;
   logic [TXN_W-1:0] current;

   // Packet that brings the count up to the limit
   assign reached_out = enable_in && packet_in && ((current + 16'h0001) >= limit);
   // Enabled reads show progress, disabled reads show the limit
   assign count_out   = enable_in ? current : limit;

   // Upper limit as written by software
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         limit <= REG_RESET;
      end else if (limit_wr_in) begin
         limit <= limit_in;
      end
   end

   // Current count: cleared by command, short packet or reaching the limit
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         current <= REG_RESET;
      end else if (clear_in) begin
         current <= REG_RESET;
      end else if (enable_in && packet_in) begin
         current <= (short_in || reached_out) ? REG_RESET : current + 16'h0001;
      end
   end
endmodule : udfp_txn_counter

/* File: hdl/udfp_port_ctrl.sv */
// DMA FIFO port control: pipe select, width, rewind, clear, buffer status
//
// How it works
// R01: Count mode 0 holds length, clears when read.
// R02: Count mode 1 decrements length per data read.
// R03: Rewind resets pointer; OUT rereads, IN restarts.
// R04: Rewind needs ready; follows new pipe selection.
// R05: Auto-clear governs zero-length and release cases.
// R06: Auto-clear 0 keeps valid; software clears buffer.
// R07: Auto-clear 1 clears buffer after last read.
// R08: Width bit picks byte or halfword access.
// R09: Width is fixed at or before pipe selection; here every select write reloads it, so it can change on a live pipe.
// R10: Transaction counting works only for OUT pipes.
// R11: Software sets every pipe to NAK first.
// R12: Counter clear command resets current count.
// R13: No reselect during access; reselect after reconfiguring.
// R14: Never share one pipe with CPU port.
// R15: Status: valid, clear, ready, reserved, length.
// R16: Ready reads 1 only when port accessible.
// R17: Buffer clear: OUT when valid, IN when not.
// R18: OUT valid rises on full, short, count, packet.
// R19: OUT valid clears on empty unless held.
// R20: IN valid write sends short or zero-length.
// R21: IN valid rises on full, max size, end pin.
// R22: Never set IN valid while already valid.
// R23: Select zero disables, one-six pipes, seven invalid.
// R24: Decrement by one byte-wide, two halfword.
// R25: Command bits pulse once and read zero.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

module udfp_port_ctrl import udfp_pkg::*; (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [15:0]       reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [15:0]       reg_rdata_out,
   input  wire logic              port_rd_in,
   input  wire logic              port_wr_in,
   input  wire logic              dma_end_pin_in,
   output logic                   dma_request_pin_out,
   output logic                   port_width_16_out,
   output logic      [PIPE_W-1:0] sel_pipe_out,
   output logic      [LEN_W-1:0]  buf_ptr_out,
   input  wire logic              cfg_dir_in_in,
   input  wire logic              cfg_continuous_in,
   input  wire logic              cfg_release_in,
   input  wire logic [LEN_W-1:0]  cfg_max_pkt_in,
   input  wire logic [LEN_W-1:0]  cfg_buf_size_in,
   input  wire logic              rx_packet_in,
   input  wire logic [LEN_W-1:0]  rx_len_in,
   output logic                   tx_request_out,
   output logic                   tx_zero_len_out,
   input  wire logic              tx_done_in
);

   // ----------------------------------------------------------------
   // Control register and decode
   // ----------------------------------------------------------------
   logic              read_count_mode;
   logic              auto_clear_mode;
   logic              port_width_select;
   logic              txn_enable;
   logic [PIPE_W-1:0] pipe_sel;
   udfp_buf_e         buf_state;
   udfp_buf_e         next_state;
   logic [LEN_W-1:0]  fill;
   logic [LEN_W-1:0]  next_fill;
   logic [LEN_W-1:0]  rd_ptr;
   logic [LEN_W-1:0]  next_rd_ptr;
   logic              next_zero_len;
   logic [LEN_W-1:0]  receive_byte_count;
   logic [TXN_W-1:0]  txn_count;
   logic              txn_reached;

   logic wr_sel;
   logic wr_st;
   logic wr_txn;
   logic pipe_change;
   logic sel_valid;
   logic is_out;
   logic is_in;
   logic buffer_valid;
   logic port_ready;
   logic [LEN_W-1:0] step;

   assign wr_sel       = reg_wr_in && (reg_addr_in == ADDR_SELECT);
   assign wr_st        = reg_wr_in && (reg_addr_in == ADDR_STATUS);
   assign wr_txn       = reg_wr_in && (reg_addr_in == ADDR_TXN);
   assign pipe_change  = wr_sel && (reg_wdata_in[SEL_PIPE_LSB +: PIPE_W] != pipe_sel);
   // R23: zero disables the port, seven is never served
   assign sel_valid    = (pipe_sel != PIPE_NONE) && (pipe_sel != PIPE_INVALID);
   assign is_out       = sel_valid && !cfg_dir_in_in;
   assign is_in        = sel_valid && cfg_dir_in_in;
   assign buffer_valid = (buf_state != UDFP_BUF_IDLE);
   // R16: ready only while the data register may be accessed
   assign port_ready   = is_out ? buffer_valid : (is_in && !buffer_valid);
   // R08: access width chosen by the width bit
   assign step         = udfp_step(port_width_select);

   // Control fields; every select write reloads them all, so width can change on a live pipe
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_count_mode   <= 1'b0;
         auto_clear_mode   <= 1'b0;
         port_width_select <= 1'b0;
         txn_enable        <= 1'b0;
         pipe_sel          <= PIPE_NONE;
      end else if (wr_sel) begin
         read_count_mode   <= reg_wdata_in[SEL_READ_COUNT_MODE_BIT];
         auto_clear_mode   <= reg_wdata_in[SEL_AUTO_CLEAR_MODE_BIT];
         port_width_select <= reg_wdata_in[SEL_MBW_BIT];
         txn_enable        <= reg_wdata_in[SEL_TXEN_BIT];
         pipe_sel          <= reg_wdata_in[SEL_PIPE_LSB +: PIPE_W];
      end
   end

   // ----------------------------------------------------------------
   // Events of the selected buffer
   // ----------------------------------------------------------------
   logic rew_go;
   logic flush_cmd;
   logic buffer_valid_cmd;
   logic out_rx;
   logic rx_short;
   logic zlp_empty;
   logic hold_case;
   logic out_rise;
   logic out_read;
   logic emptied;
   logic in_write;
   logic in_full;
   logic [10:0] rx_sum;
   logic [10:0] rd_sum;
   logic [10:0] wr_sum;

   // R04: rewind while ready, or on the pipe being newly selected
   assign rew_go    = wr_sel && reg_wdata_in[SEL_REW_BIT] && (pipe_change || port_ready);
   assign flush_cmd = wr_st && reg_wdata_in[ST_FLUSH_BIT];
   assign buffer_valid_cmd  = wr_st && reg_wdata_in[ST_BUFFER_VALID_BIT];
   assign out_rx    = is_out && rx_packet_in && !buffer_valid;
   assign rx_short  = rx_len_in < cfg_max_pkt_in;
   assign rx_sum    = udfp_add(fill, rx_len_in);
   assign rd_sum    = udfp_add(rd_ptr, step);
   assign wr_sum    = udfp_add(fill, step);
   // R05: cases in which auto-clear decides who frees the buffer
   assign zlp_empty = (rx_len_in == LEN_ZERO) && (fill == LEN_ZERO);
   assign hold_case = zlp_empty || (cfg_release_in && (rx_short || txn_reached));
   // R18: full or short in continuous mode, count reached, any packet otherwise
   assign out_rise  = !cfg_continuous_in || rx_short || txn_reached
                      || (rx_sum >= {1'b0, cfg_buf_size_in});
   assign out_read  = is_out && port_rd_in && port_ready && (rd_ptr < fill);
   assign emptied   = out_read && (rd_sum >= {1'b0, fill});
   assign in_write  = is_in && port_wr_in && port_ready;
   // R21: full in continuous mode, max packet size otherwise
   assign in_full   = cfg_continuous_in ? (wr_sum >= {1'b0, cfg_buf_size_in})
                                        : (wr_sum >= {1'b0, cfg_max_pkt_in});

   // Next buffer state; reselection forgets the previous pipe's progress
   always_comb begin
      next_state    = buf_state;
      next_fill     = fill;
      next_rd_ptr   = rd_ptr;
      next_zero_len = tx_zero_len_out;
      if (pipe_change || !sel_valid) begin
         next_state    = UDFP_BUF_IDLE;
         next_fill     = LEN_ZERO;
         next_rd_ptr   = LEN_ZERO;
         next_zero_len = 1'b0;
      end else if (is_out) begin
         // R17: OUT clear acts only on a valid buffer
         if (flush_cmd && buffer_valid) begin
            next_state  = UDFP_BUF_IDLE;
            next_fill   = LEN_ZERO;
            next_rd_ptr = LEN_ZERO;
         // R03: reread from the start
         end else if (rew_go) begin
            next_rd_ptr = LEN_ZERO;
         end else if (out_rx) begin
            next_fill = rx_sum[LEN_W-1:0];
            if (out_rise) begin
               // R06: held until software clears it
               if (hold_case && !auto_clear_mode) begin
                  next_state = UDFP_BUF_HELD;
               // R07: nothing to read, so clear at once
               end else if (zlp_empty) begin
                  next_fill = LEN_ZERO;
               end else begin
                  next_state = UDFP_BUF_VALID;
               end
            end
         end else if (out_read) begin
            next_rd_ptr = rd_sum[LEN_W-1:0];
            // R19: drained buffer frees itself unless held
            if (emptied && buf_state == UDFP_BUF_VALID) begin
               next_state  = UDFP_BUF_IDLE;
               next_fill   = LEN_ZERO;
               next_rd_ptr = LEN_ZERO;
            end
         end
      end else begin
         // R20: valid with clear sends a zero-length packet
         if (buffer_valid_cmd && flush_cmd && !buffer_valid) begin
            next_state    = UDFP_BUF_VALID;
            next_fill     = LEN_ZERO;
            next_zero_len = 1'b1;
         // R17: IN clear acts only while not yet valid
         end else if (flush_cmd && !buffer_valid) begin
            next_fill = LEN_ZERO;
         // R03: discard everything written so far
         end else if (rew_go) begin
            next_fill = LEN_ZERO;
         // R20: hand the short packet over
         end else if (buffer_valid_cmd && !buffer_valid) begin
            next_state = UDFP_BUF_VALID;
         end else if (in_write) begin
            next_fill = wr_sum[LEN_W-1:0];
            // R21: buffer complete
            if (in_full || dma_end_pin_in) begin
               next_state = UDFP_BUF_VALID;
            end
         // R21: end pin closes a partly filled buffer
         end else if (dma_end_pin_in && !buffer_valid) begin
            next_state = UDFP_BUF_VALID;
         end else if (tx_done_in && buffer_valid) begin
            next_state    = UDFP_BUF_IDLE;
            next_fill     = LEN_ZERO;
            next_zero_len = 1'b0;
         end
      end
   end

   // Buffer state and pointers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         buf_state       <= UDFP_BUF_IDLE;
         fill            <= LEN_ZERO;
         rd_ptr          <= LEN_ZERO;
         tx_zero_len_out <= 1'b0;
      end else begin
         buf_state       <= next_state;
         fill            <= next_fill;
         rd_ptr          <= next_rd_ptr;
         tx_zero_len_out <= next_zero_len;
      end
   end

   // ----------------------------------------------------------------
   // Length tracker and transaction counter
   // ----------------------------------------------------------------
   logic len_clear;
   logic len_load;

   // R01: clear after the last read in hold mode 0, but a held buffer keeps it
   assign len_clear = pipe_change || !is_out || (next_state == UDFP_BUF_IDLE && buffer_valid);
   assign len_load  = (out_rx && next_state != UDFP_BUF_IDLE) || (rew_go && is_out);

   // R02: decrement per read in count mode 1
   // R24: by the access width
   udfp_len_tracker u_len (
      .ref_clk_in  (ref_clk_in),
      .rst_n_in    (rst_n_in),
      .clear_in    (len_clear),
      .load_in     (len_load),
      .load_val_in (next_fill),
      .dec_in      (out_read && read_count_mode),
      .step_in     (step),
      .len_out     (receive_byte_count)
   );

   // R10: counts only with enable set and an OUT pipe selected
   // R12: clear command resets the running count
   udfp_txn_counter u_txn (
      .ref_clk_in  (ref_clk_in),
      .rst_n_in    (rst_n_in),
      .limit_wr_in (wr_txn),
      .limit_in    (reg_wdata_in),
      .enable_in   (txn_enable && is_out),
      .clear_in    (wr_sel && reg_wdata_in[SEL_TXCLR_BIT]),
      .packet_in   (out_rx),
      .short_in    (rx_short),
      .count_out   (txn_count),
      .reached_out (txn_reached)
   );

   // ----------------------------------------------------------------
   // Outputs and register readback
   // ----------------------------------------------------------------
   assign dma_request_pin_out = port_ready;
   assign port_width_16_out   = port_width_select;
   assign sel_pipe_out        = pipe_sel;
   assign buf_ptr_out         = is_out ? rd_ptr : fill;
   assign tx_request_out      = is_in && buffer_valid;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= REG_RESET;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            // R25: command bits always read back as zero
            ADDR_SELECT: reg_rdata_out <= {read_count_mode, 1'b0, auto_clear_mode, 2'b00,
                                           port_width_select, txn_enable, 1'b0, 5'h00, pipe_sel};
            // R15: valid, clear, ready, three reserved, length
            ADDR_STATUS: reg_rdata_out <= {buffer_valid, 1'b0, port_ready, 3'h0, receive_byte_count};
            ADDR_TXN:    reg_rdata_out <= txn_count;
            default:     reg_rdata_out <= REG_RESET;
         endcase
      end else begin
         reg_rdata_out <= REG_RESET;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic quiet;
   assign quiet = !reg_wr_in && !rx_packet_in;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_zlp_write;
      wr_st && reg_wdata_in[ST_BUFFER_VALID_BIT] && reg_wdata_in[ST_FLUSH_BIT] && is_in && !buffer_valid;
   endsequence
   sequence s_zlp_sent;
      buffer_valid && tx_zero_len_out && tx_request_out && (buf_ptr_out == LEN_ZERO);
   endsequence

   AST_LEN_HOLD: assert property (out_read && !read_count_mode && !emptied && quiet // R01
      |=> $stable(receive_byte_count)) else $error("Length moved in hold mode");
   AST_LEN_DEC: assert property (out_read && read_count_mode && !emptied && quiet // R24
      && receive_byte_count > step |=> receive_byte_count == $past(receive_byte_count) - $past(step))
      else $error("Length did not drop by access width");
   AST_REWIND: assert property (rew_go && is_out && !pipe_change && !flush_cmd // R03
      |=> rd_ptr == LEN_ZERO ##1 port_ready) else $error("Rewind did not reset read pointer");
   AST_AUTO_CLEAR: assert property (emptied && buf_state == UDFP_BUF_VALID && quiet // R07
      |=> !buffer_valid && receive_byte_count == LEN_ZERO) else $error("Drained buffer not cleared");
   AST_HELD: assert property (emptied && buf_state == UDFP_BUF_HELD && quiet // R06
      |=> buffer_valid [*2]) else $error("Held buffer released without clear");
   AST_READY: assert property (port_ready |-> sel_valid // R16
      && (is_out == buffer_valid)) else $error("Ready on a disabled or busy port");
   AST_CMD_ZERO: assert property (reg_rd_in && reg_addr_in == ADDR_SELECT // R25
      |=> reg_rdata_out[SEL_REW_BIT] == 1'b0 && reg_rdata_out[SEL_TXCLR_BIT] == 1'b0)
      else $error("Command bit read back as one");
   AST_FLUSH_OUT: assert property (flush_cmd && is_out && buffer_valid && !pipe_change // R17
      |=> !buffer_valid && rd_ptr == LEN_ZERO) else $error("Out buffer clear ignored");
   AST_ZLP: assert property ((s_zlp_write and !pipe_change) |=> s_zlp_sent) // R20
      else $error("Zero-length send not started");
   AST_IN_END: assert property (is_in && dma_end_pin_in && !buffer_valid && quiet // R21
      && !tx_done_in |=> buffer_valid && !port_ready) else $error("End pin did not close buffer");

endmodule : udfp_port_ctrl

/* File: tb/udfp_sie_model.sv */
// Serial engine stand-in that finishes each IN send after a set delay
`timescale 1ns/1ps
module udfp_sie_model (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [3:0] delay_in,
   input  wire logic       tx_request_in,
   output logic            tx_done_out
);
   logic [3:0] wait_cnt;
   // send completes after delay_in idle cycles, one done pulse each
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_cnt    <= 4'h0;
         tx_done_out <= 1'b0;
      end else begin
         tx_done_out <= tx_request_in && !tx_done_out && (wait_cnt == delay_in);
         wait_cnt    <= (tx_request_in && !tx_done_out) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : udfp_sie_model

/* File: tb/udfp_bench.sv */
// Self-checking bench of the DMA FIFO port control block
`timescale 1ns/1ps
module usb_dma_fifo_port_control_bench import udfp_pkg::*;;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, prd = 0, pwr = 0, end_pin = 0;
   logic dir = 0, rel = 0, rxp = 0, cont = 0, txd, dma_request_pin, w16, txr, txz;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, got;
   logic [9:0] maxp = 10'h040, rxl = 10'h000, ptr;
   logic [2:0] sel, p;
   logic [3:0] dly = 4'h0;
   logic [31:0] seed = 32'hfe0e0191;
   int mismatches = 0, check_count = 0, n;
   always #20 clk = ~clk;
   udfp_port_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .port_rd_in(prd), .port_wr_in(pwr),
      .dma_end_pin_in(end_pin), .dma_request_pin_out(dma_request_pin), .port_width_16_out(w16),
      .sel_pipe_out(sel), .buf_ptr_out(ptr), .cfg_dir_in_in(dir), .cfg_continuous_in(cont),
      .cfg_release_in(rel), .cfg_max_pkt_in(maxp), .cfg_buf_size_in(10'h040), .rx_packet_in(rxp),
      .rx_len_in(rxl), .tx_request_out(txr), .tx_zero_len_out(txz), .tx_done_in(txd));
   udfp_sie_model sie (.ref_clk_in(clk), .rst_n_in(rst_n), .delay_in(dly), .tx_request_in(txr),
      .tx_done_out(txd));
   // Expectation helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [15:0] st(input logic v, input logic r, input logic [9:0] l);
      st = {v, 1'b0, r, 3'h0, l};
   endfunction : st
   function automatic logic [15:0] ctl(input logic [3:0] m, input logic [2:0] q);
      ctl = {m[3:1], 2'h0, m[0], 7'h00, q};
   endfunction : ctl
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Bus cycles; strobes are single cycles launched after an edge
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask : rreg
   // Back-to-back data port accesses, cnt of them
   task automatic port(input logic w, input int cnt);
      @(posedge clk);
      prd <= !w;
      pwr <= w;
      repeat (cnt) @(posedge clk);
      prd <= 1'b0;
      pwr <= 1'b0;
   endtask : port
   task automatic pkt(input logic [9:0] l, input logic r);
      @(posedge clk);
      rxp <= 1'b1;
      rxl <= l;
      rel <= r;
      @(posedge clk);
      rxp <= 1'b0;
   endtask : pkt
   task automatic wait_tx;
      for (int i = 0; i < 40 && txr === 1'b1; i++) @(negedge clk);
   endtask : wait_tx
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(ADDR_SELECT);
      chk(got, REG_RESET);
      rreg(8'h3e);
      chk(got, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         n = 2 * (seed[3:0] + 2);
         p = 3'(seed[6:4] % 6 + 1);
         wreg(ADDR_SELECT, ctl({3'b101, i[0]}, p));
         cont <= i[1];
         pkt(n[9:0], 1'b0);
         rreg(ADDR_STATUS);
         chk(got, st(1'b1, 1'b1, n[9:0]));
         chk({15'h0, w16}, {15'h0, i[0]});
         chk({13'h0, sel}, {13'h0, p});
         chk({15'h0, dma_request_pin}, 16'h0001);
         port(1'b0, 1);
         rreg(ADDR_STATUS);
         chk(got, st(1'b1, 1'b1, n[9:0] - (i[0] ? 10'h2 : 10'h1)));
         port(1'b0, i[0] ? n / 2 - 1 : n - 1);
         rreg(ADDR_STATUS);
         chk(got, 16'h0000);
      end
      wreg(ADDR_SELECT, ctl(4'h2, 3'h1));
      pkt(10'h006, 1'b0);
      port(1'b0, 2);
      rreg(ADDR_STATUS);
      chk(got, st(1'b1, 1'b1, 10'h006));
      chk({6'h0, ptr}, 16'h0002);
      wreg(ADDR_SELECT, ctl(4'h6, 3'h1));
      rreg(ADDR_SELECT);
      chk(got, ctl(4'h2, 3'h1));
      chk({6'h0, ptr}, 16'h0000);
      port(1'b0, 5);
      rreg(ADDR_STATUS);
      chk(got, st(1'b1, 1'b1, 10'h006));
      port(1'b0, 1);
      rreg(ADDR_STATUS);
      chk(got, 16'h0000);
      for (int a = 0; a < 2; a++) begin
         wreg(ADDR_SELECT, ctl({2'b00, a[0], 1'b0}, 3'h3));
         pkt(10'h003, 1'b1);
         port(1'b0, 3);
         rreg(ADDR_STATUS);
         chk(got & 16'h83ff, a ? 16'h0000 : 16'h8003);
         wreg(ADDR_STATUS, 16'h4000);
         rreg(ADDR_STATUS);
         chk(got, 16'h0000);
      end
      $display("out pipe tests done");
      @(posedge clk);
      dir <= 1'b1;
      cont <= 1'b0;
      maxp <= 10'h004;
      dly <= 4'hf;
      wreg(ADDR_SELECT, ctl(4'h0, 3'h2));
      rreg(ADDR_STATUS);
      chk(got & 16'ha000, st(1'b0, 1'b1, 10'h000));
      port(1'b1, 4);
      rreg(ADDR_STATUS);
      chk(got & 16'ha000, 16'h8000);
      wait_tx();
      chk({15'h0, txr}, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         if (k != 1) port(1'b1, 1);
         @(posedge clk);
         dly <= seed[3:0];
         end_pin <= (k == 2);
         if (k != 2) wreg(ADDR_STATUS, k ? 16'hc000 : 16'h8000);
         else @(posedge clk);
         end_pin <= 1'b0;
         @(negedge clk);
         chk({14'h0, txr, txz}, {14'h0, 1'b1, k == 1});
         wait_tx();
         chk({15'h0, txr}, 16'h0000);
      end
      $display("in pipe tests done");
      wreg(ADDR_TXN, seed[15:0]);
      wreg(ADDR_SELECT, 16'h0202);
      rreg(ADDR_TXN);
      chk(got, seed[15:0]);
      wreg(ADDR_SELECT, 16'h0000);
      rreg(ADDR_STATUS);
      chk(got, 16'h0000);
      chk({15'h0, dma_request_pin}, 16'h0000);
      $display("port disable tests done");
      stop_test();
   end
endmodule : usb_dma_fifo_port_control_bench
